// file: rtl/bridge_pwm_fault_gate.sv
// Full-bridge PWM output stage with dead time, direction hold, overcurrent shutdown and AHB-Lite registers.
//
// Contract
// - Left upper command follows the duty pulse; left lower command is its inverse.
// - While shutdown is set the duty buffer enable is released.
// - While shutdown is set both left commands are forced low.
// - Dead time separates the complementary commands; a leg never conducts on both switches.
// - Direction input holds right upper on for one sense, right lower for the other.
// - Four separate gate commands: left upper, left lower, right upper, right lower.
// - Supply-good release rises only after a fixed delay once supply is present.
// - Supply loss discharges the delay; release drops and the full delay restarts.
// - Enable condition is no-overcurrent AND supply-good release.
// - With enable condition high, shutdown clears at the first switching clock rise.
// - Switching clock path is delayed so the enable condition settles first.
// - Overcurrent sets shutdown at once, without waiting for a switching clock edge.
// - After overcurrent ends, shutdown clears only at the next switching clock rise.
// - Overcurrent indication is active low.
// - Charge-pump refresh is a free 62.5 kHz, 50 percent square wave.
`timescale 1ns/10ps

module bridge_pwm_fault_gate #(
    parameter int SUPPLY_DELAY = bridge_pwm_pkg::SUPPLY_DELAY_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic dutyPulse,
    input wire logic switchClk,
    input wire logic no_overcurrent_ind,
    input wire logic supplyPresent,
    input wire logic direction_select,
    output logic left_upper_gate_cmd,
    output logic left_lower_gate_cmd,
    output logic right_upper_gate_cmd,
    output logic right_lower_gate_cmd,
    output logic dutyBufferEn,
    output logic shutdownFlag,
    output logic supplyGoodRelease,
    output logic chargePumpRefresh,
    output logic irq,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import bridge_pwm_pkg::*;

    localparam logic [SUPPLY_CNT_W-1:0] SUPPLY_TARGET = SUPPLY_CNT_W'(SUPPLY_DELAY);

    // Two-stage synchronisers for every pin; the switching clock gets a third stage.
    logic [PIN_W-1:0] pinMeta_q;
    logic [PIN_W-1:0] pinSync_q;
    logic swClkDly_q;
    logic swClkPrev_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            pinMeta_q <= {direction_select, supplyPresent, no_overcurrent_ind, switchClk, dutyPulse};
            pinSync_q <= pinMeta_q;
        end
    end

    // The extra stage lets the enable condition settle a cycle ahead of the clearing edge.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            swClkDly_q <= 1'b0;
            swClkPrev_q <= 1'b0;
        end else begin
            swClkDly_q <= pinSync_q[PIN_SWCLK];
            swClkPrev_q <= swClkDly_q;
        end
    end

    logic dutyLvl;
    logic overcurrent;
    logic dirLvl;
    logic swClkRise;
    assign dutyLvl = pinSync_q[PIN_DUTY];
    assign overcurrent = !pinSync_q[PIN_NO_OC];
    assign dirLvl = pinSync_q[PIN_DIR];
    assign swClkRise = swClkDly_q && !swClkPrev_q;

    // Supply-good release delay.
    logic [SUPPLY_CNT_W-1:0] supplyCnt_q;
    logic supplyGood_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            supplyCnt_q <= '0;
            supplyGood_q <= 1'b0;
        end else if (!pinSync_q[PIN_SUPPLY]) begin
            supplyCnt_q <= '0;
            supplyGood_q <= 1'b0;
        end else if (supplyCnt_q >= SUPPLY_TARGET) begin
            supplyGood_q <= 1'b1;
        end else begin
            supplyCnt_q <= supplyCnt_q + 1'b1;
        end
    end

    // Shutdown flag: set while the enable condition is low, cleared by a switching clock rise.
    logic gated_enable_cond;
    logic shutdown_q;
    assign gated_enable_cond = !overcurrent && supplyGood_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shutdown_q <= 1'b1;
        end else if (!gated_enable_cond) begin
            shutdown_q <= 1'b1;
        end else if (swClkRise) begin
            shutdown_q <= 1'b0;
        end
    end

    // Software control registers.
    logic ctrlEnable_q;
    logic [CNT_W-1:0] deadTime_q;
    logic [IRQ_W-1:0] irqMask_q;
    logic [IRQ_W-1:0] irqStatus_q;
    logic [CNT_W-1:0] tripCount_q;
    logic [CNT_W-1:0] deadEff;
    assign deadEff = (deadTime_q < DEAD_MIN) ? DEAD_MIN : deadTime_q;

    // Dead-time qualifiers: phase 0 waits for the duty pulse high, phase 1 for it low.
    logic [1:0] phaseOk;
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_phase
            logic [CNT_W-1:0] holdCnt_q;
            logic phaseLvl;
            assign phaseLvl = (p == 0) ? dutyLvl : !dutyLvl;
            assign phaseOk[p] = phaseLvl && (holdCnt_q >= deadEff);
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    holdCnt_q <= '0;
                end else if (!phaseLvl) begin
                    holdCnt_q <= '0;
                end else if (holdCnt_q < deadEff) begin
                    holdCnt_q <= holdCnt_q + 1'b1;
                end
            end
        end
    endgenerate

    // Direction changes also get a dead time so the right leg breaks before it makes.
    logic dirPrev_q;
    logic [CNT_W-1:0] dirCnt_q;
    logic dirOk;
    assign dirOk = (dirLvl == dirPrev_q) && (dirCnt_q >= deadEff);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dirPrev_q <= 1'b0;
            dirCnt_q <= '0;
        end else begin
            dirPrev_q <= dirLvl;
            if (dirLvl != dirPrev_q) begin
                dirCnt_q <= '0;
            end else if (dirCnt_q < deadEff) begin
                dirCnt_q <= dirCnt_q + 1'b1;
            end
        end
    end

    // Gate command flip-flops.
    logic runLeft;
    logic runRight;
    assign runLeft = ctrlEnable_q && !shutdown_q;
    assign runRight = ctrlEnable_q && supplyGood_q && dirOk;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            left_upper_gate_cmd <= 1'b0;
            left_lower_gate_cmd <= 1'b0;
            right_upper_gate_cmd <= 1'b0;
            right_lower_gate_cmd <= 1'b0;
            dutyBufferEn <= 1'b0;
            shutdownFlag <= 1'b1;
            supplyGoodRelease <= 1'b0;
        end else begin
            left_upper_gate_cmd <= runLeft && phaseOk[0];
            left_lower_gate_cmd <= runLeft && phaseOk[1];
            right_upper_gate_cmd <= runRight && dirLvl;
            right_lower_gate_cmd <= runRight && !dirLvl;
            dutyBufferEn <= !shutdown_q;
            shutdownFlag <= shutdown_q;
            supplyGoodRelease <= supplyGood_q;
        end
    end

    // Charge-pump refresh runs from reset regardless of duty or shutdown.
    logic [CNT_W-1:0] pumpCnt_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pumpCnt_q <= '0;
            chargePumpRefresh <= 1'b0;
        end else if (pumpCnt_q == PUMP_HALF_CYCLES - 1'b1) begin
            pumpCnt_q <= '0;
            chargePumpRefresh <= !chargePumpRefresh;
        end else begin
            pumpCnt_q <= pumpCnt_q + 1'b1;
        end
    end

    // Interrupt events.
    logic shutdownPrev_q;
    logic supplyPrev_q;
    logic [IRQ_W-1:0] irqEvent;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shutdownPrev_q <= 1'b1;
            supplyPrev_q <= 1'b0;
        end else begin
            shutdownPrev_q <= shutdown_q;
            supplyPrev_q <= supplyGood_q;
        end
    end

    always_comb begin
        irqEvent = '0;
        irqEvent[IRQ_TRIP_BIT] = shutdown_q && !shutdownPrev_q;
        irqEvent[IRQ_RESUME_BIT] = !shutdown_q && shutdownPrev_q;
        irqEvent[IRQ_SUPPLY_BIT] = supplyGood_q && !supplyPrev_q;
    end

    // Trip counter saturates so a stuck fault cannot wrap back to a small count.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tripCount_q <= '0;
        end else if (irqEvent[IRQ_TRIP_BIT] && (tripCount_q != '1)) begin
            tripCount_q <= tripCount_q + 1'b1;
        end
    end

    // AHB-Lite slave: zero wait states, address phase captured, write applied in the data phase.
    logic wrPending_q;
    logic [7:0] wrAddr_q;
    logic addrPhase;
    assign addrPhase = hsel && htrans[1] && hready;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wrPending_q <= 1'b0;
            wrAddr_q <= '0;
        end else begin
            wrPending_q <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddr_q <= haddr[7:0];
            end
        end
    end

    logic wrCtrl;
    logic wrIrqStatus;
    logic wrIrqMask;
    logic wrDead;
    assign wrCtrl = wrPending_q && (wrAddr_q == ADDR_CTRL);
    assign wrIrqStatus = wrPending_q && (wrAddr_q == ADDR_IRQ_STATUS);
    assign wrIrqMask = wrPending_q && (wrAddr_q == ADDR_IRQ_MASK);
    assign wrDead = wrPending_q && (wrAddr_q == ADDR_DEAD_TIME);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrlEnable_q <= CTRL_ENABLE_RESET;
            deadTime_q <= DEAD_CYCLES;
            irqMask_q <= IRQ_MASK_RESET;
        end else begin
            if (wrCtrl) begin
                ctrlEnable_q <= hwdata[CTRL_ENABLE_BIT];
            end
            if (wrDead) begin
                deadTime_q <= hwdata[CNT_W-1:0];
            end
            if (wrIrqMask) begin
                irqMask_q <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irqStatus_q <= '0;
        end else if (wrIrqStatus) begin
            irqStatus_q <= (irqStatus_q & ~hwdata[IRQ_W-1:0]) | irqEvent;
        end else begin
            irqStatus_q <= irqStatus_q | irqEvent;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_q & irqMask_q);
        end
    end

    // Read data is sampled in the address phase; unmapped addresses read as zero.
    logic [31:0] rdMux;

    always_comb begin
        rdMux = '0;
        unique case (haddr[7:0])
            ADDR_CTRL: rdMux[CTRL_ENABLE_BIT] = ctrlEnable_q;
            ADDR_STATUS: begin
                rdMux[ST_SHUTDOWN_BIT] = shutdown_q;
                rdMux[ST_SUPPLY_BIT] = supplyGood_q;
                rdMux[ST_NO_OC_BIT] = !overcurrent;
                rdMux[ST_DIR_BIT] = dirLvl;
                rdMux[ST_DUTY_BIT] = dutyLvl;
            end
            ADDR_IRQ_STATUS: rdMux[IRQ_W-1:0] = irqStatus_q;
            ADDR_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMask_q;
            ADDR_DEAD_TIME: rdMux[CNT_W-1:0] = deadTime_q;
            ADDR_TRIP_COUNT: rdMux[CNT_W-1:0] = tripCount_q;
            default: rdMux = '0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hrdata <= '0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addrPhase && !hwrite) begin
                hrdata <= rdMux;
            end
        end
    end

endmodule

// file: rtl/bridge_pwm_pkg.sv
// Constants shared by the bridge PWM output stage: register map, bit fields and timing.
package bridge_pwm_pkg;

    // Register byte addresses on the AHB-Lite bus.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_DEAD_TIME = 8'h10;
    localparam logic [7:0] ADDR_TRIP_COUNT = 8'h14;

    // Control register fields.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

    // Live status register fields.
    localparam int ST_SHUTDOWN_BIT = 0;
    localparam int ST_SUPPLY_BIT = 1;
    localparam int ST_NO_OC_BIT = 2;
    localparam int ST_DIR_BIT = 3;
    localparam int ST_DUTY_BIT = 4;

    // Interrupt status and mask fields.
    localparam int IRQ_W = 3;
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_RESUME_BIT = 1;
    localparam int IRQ_SUPPLY_BIT = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    // Synchronised pin vector positions.
    localparam int PIN_W = 5;
    localparam int PIN_DUTY = 0;
    localparam int PIN_SWCLK = 1;
    localparam int PIN_NO_OC = 2;
    localparam int PIN_SUPPLY = 3;
    localparam int PIN_DIR = 4;

    // Timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEAD_TIME_NS = 500;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] DEAD_CYCLES = CNT_W'((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DEAD_MIN = 16'h0001;
    localparam int PUMP_HALF_PERIOD_NS = 8000;
    localparam logic [CNT_W-1:0] PUMP_HALF_CYCLES = CNT_W'(PUMP_HALF_PERIOD_NS / CLK_PERIOD_NS);
    localparam int SUPPLY_DELAY_US = 10000;
    localparam int SUPPLY_DELAY_CYCLES = (SUPPLY_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int SUPPLY_CNT_W = 24;

endpackage

// file: test/bridge_pwm_fault_gate_sva.sv
// Concurrent checks on the pins of the bridge PWM output stage.
`timescale 1ns/10ps
module bridge_pwm_fault_gate_sva #(
    parameter int SUPPLY_DELAY = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic switchClk,
    input wire logic no_overcurrent_ind,
    input wire logic supplyPresent,
    input wire logic left_upper_gate_cmd,
    input wire logic left_lower_gate_cmd,
    input wire logic right_upper_gate_cmd,
    input wire logic right_lower_gate_cmd,
    input wire logic dutyBufferEn,
    input wire logic shutdownFlag,
    input wire logic supplyGoodRelease,
    input wire logic chargePumpRefresh
);
    int lowCnt_q;
    int hiCnt_q;
    int swAge_q;
    int pumpAge_q;
    logic swPrev_q;
    logic pumpPrev_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Counts cycles since the lower left switch was last on, so a re-enable after a long blank is no hazard.
    always_ff @(posedge core_clk) begin
        lowCnt_q <= left_lower_gate_cmd ? 0 : lowCnt_q + 1;
        hiCnt_q <= supplyPresent ? hiCnt_q + 1 : 0;
        swPrev_q <= switchClk;
        pumpPrev_q <= chargePumpRefresh;
        swAge_q <= !rst_n ? 100 : ((switchClk && !swPrev_q) ? 0 : swAge_q + 1);
        pumpAge_q <= (!rst_n || chargePumpRefresh != pumpPrev_q) ? 0 : pumpAge_q + 1;
    end
    // The pin passes three flops before it can clear the flag, so allow a short lag.
    sequence swRecent;
        swAge_q <= 8;
    endsequence
    sequence ocHeld;
        !no_overcurrent_ind [*6];
    endsequence
    a_leg_exclusive: assert property (!(left_upper_gate_cmd && left_lower_gate_cmd)
        && !(right_upper_gate_cmd && right_lower_gate_cmd))
        else $error("Both switches of a leg on.");
    a_dead_gap: assert property ($rose(left_upper_gate_cmd) |-> lowCnt_q >= 45)
        else $error("Upper switch on without dead time.");
    a_shut_blanks: assert property (shutdownFlag [*2] |-> !left_upper_gate_cmd && !left_lower_gate_cmd)
        else $error("Left gates on during shutdown.");
    a_buffer_off: assert property (shutdownFlag [*2] |-> !dutyBufferEn)
        else $error("Duty buffer enabled during shutdown.");
    a_oc_sets: assert property (ocHeld |-> shutdownFlag)
        else $error("Overcurrent did not set shutdown.");
    a_clear_edge: assert property ($fell(shutdownFlag) |-> swRecent)
        else $error("Shutdown cleared without switching clock rise.");
    a_supply_delay: assert property ($rose(supplyGoodRelease) |-> hiCnt_q >= SUPPLY_DELAY + 3)
        else $error("Supply release came too early.");
    a_supply_drop: assert property (!supplyPresent [*5] |-> !supplyGoodRelease)
        else $error("Supply release stayed high after supply loss.");
    // The first edges in reset would see the unknown start value change, so cycles in reset are left out.
    a_pump_period: assert property (rst_n && $changed(chargePumpRefresh) |-> pumpAge_q inside {[795:802]})
        else $error("Charge pump half period wrong.");
endmodule

bind bridge_pwm_fault_gate bridge_pwm_fault_gate_sva #(.SUPPLY_DELAY(SUPPLY_DELAY)) chk (
    .core_clk, .rst_n, .switchClk, .no_overcurrent_ind, .supplyPresent, .left_upper_gate_cmd,
    .left_lower_gate_cmd, .right_upper_gate_cmd, .right_lower_gate_cmd, .dutyBufferEn,
    .shutdownFlag, .supplyGoodRelease, .chargePumpRefresh
);

// file: test/bridge_pwm_fault_gate_tb.sv
// Self-checking bench for the bridge PWM output stage.
`timescale 1ns/10ps
module bridge_pwm_fault_gate_tb;
    import bridge_pwm_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic dutyPulse = 1'b0;
    logic switchClk = 1'b0;
    logic supplyPresent = 1'b0;
    logic direction_select = 1'b0;
    logic overload = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic noOc, lUp, lLow, rUp, rLow, bufEn, shut, sGood, irq, hreadyout, hresp;
    logic [31:0] hrdata;
    logic [31:0] rd;
    int overlapCount;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    // Columns: duty, direction, left upper, left lower, right upper, right lower.
    logic [5:0] rows [4] = '{6'h16, 6'h29, 6'h05, 6'h3a};
    bridge_pwm_fault_gate #(.SUPPLY_DELAY(20)) uut (
        .core_clk, .rst_n, .dutyPulse, .switchClk, .no_overcurrent_ind(noOc), .supplyPresent,
        .direction_select, .left_upper_gate_cmd(lUp), .left_lower_gate_cmd(lLow),
        .right_upper_gate_cmd(rUp), .right_lower_gate_cmd(rLow), .dutyBufferEn(bufEn),
        .shutdownFlag(shut), .supplyGoodRelease(sGood), .chargePumpRefresh(), .irq, .hsel(1'b1),
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp
    );
    gate_driver_model partner (
        .core_clk, .leftUp(lUp), .leftLow(lLow), .rightUp(rUp), .rightLow(rLow), .overload,
        .noOvercurrent(noOc), .overlapCount
    );
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        begin
            $display("Comparisons %0d, mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic chkBit(input logic got, input logic exp);
        begin
            check_count++;
            if (got !== exp) begin
                failures++;
                $display("Error at %0t: bit %b, expected %b", $time, got, exp);
            end
        end
    endtask
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count++;
            if (got !== exp) begin
                failures++;
                $display("Error at %0t: word %h, expected %h", $time, got, exp);
            end
        end
    endtask
    // Ends just after a falling edge, where registered outputs have settled.
    task automatic waitCyc(input int n);
        begin
            repeat (n) @(posedge core_clk);
            @(negedge core_clk);
        end
    endtask
    // The leading edge leaves one idle cycle, so a read never overlaps a write just before it.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge core_clk);
            haddr <= {24'h0, a};
            htrans <= 2'h2;
            hwrite <= w;
            do @(posedge core_clk); while (hreadyout !== 1'b1);
            htrans <= 2'h0;
            hwdata <= d;
            do @(posedge core_clk); while (hreadyout !== 1'b1);
            rd = hrdata;
        end
    endtask
    task automatic pulseSw;
        begin
            @(posedge core_clk);
            switchClk <= 1'b1;
            repeat (3) @(posedge core_clk);
            switchClk <= 1'b0;
            waitCyc(8);
        end
    endtask
    initial begin
        waitCyc(1);
        chkBit(shut, 1'b1);
        chkBit(lUp | lLow | rUp | rLow | bufEn, 1'b0);
        @(posedge core_clk);
        rst_n <= 1'b1;
        supplyPresent <= 1'b1;
        waitCyc(14);
        chkBit(sGood, 1'b0);
        pulseSw();
        chkBit(shut, 1'b1);
        waitCyc(6);
        chkBit(sGood, 1'b1);
        pulseSw();
        chkBit(shut, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            dutyPulse <= rows[i][5];
            direction_select <= rows[i][4];
            waitCyc(70);
            chkBit(lUp, rows[i][3]);
            chkBit(lLow, rows[i][2]);
            chkBit(rUp, rows[i][1]);
            chkBit(rLow, rows[i][0]);
        end
        xfer(1'b0, ADDR_CTRL, 32'h0);
        chkWord(rd, 32'h1);
        chkBit(hresp, 1'b0);
        xfer(1'b0, ADDR_DEAD_TIME, 32'h0);
        chkWord(rd, 32'h32);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chkWord(rd, 32'h1e);
        xfer(1'b0, 8'h40, 32'h0);
        chkWord(rd, 32'h0);
        xfer(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chkWord(rd, 32'h6);
        xfer(1'b1, ADDR_IRQ_MASK, 32'h7);
        waitCyc(2);
        chkBit(irq, 1'b1);
        xfer(1'b1, ADDR_IRQ_STATUS, 32'h7);
        waitCyc(2);
        chkBit(irq, 1'b0);
        @(posedge core_clk);
        overload <= 1'b1;
        waitCyc(6);
        chkBit(shut, 1'b1);
        chkBit(lUp | lLow | bufEn, 1'b0);
        chkBit(rUp, 1'b1);
        chkBit(irq, 1'b1);
        pulseSw();
        chkBit(shut, 1'b1);
        @(posedge core_clk);
        overload <= 1'b0;
        waitCyc(10);
        chkBit(shut, 1'b1);
        pulseSw();
        chkBit(shut, 1'b0);
        waitCyc(70);
        chkBit(lUp, 1'b1);
        xfer(1'b0, ADDR_TRIP_COUNT, 32'h0);
        chkWord(rd, 32'h1);
        xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
        xfer(1'b1, ADDR_IRQ_STATUS, 32'h7);
        @(posedge core_clk);
        supplyPresent <= 1'b0;
        waitCyc(6);
        chkBit(sGood, 1'b0);
        chkBit(shut, 1'b1);
        chkBit(irq, 1'b0);
        @(posedge core_clk);
        supplyPresent <= 1'b1;
        waitCyc(14);
        chkBit(sGood, 1'b0);
        xfer(1'b1, ADDR_IRQ_MASK, 32'h1);
        waitCyc(2);
        chkBit(irq, 1'b1);
        // A reset in mid-run must set shutdown, blank the gates, buffer enable, release and irq, and restart the supply delay.
        @(posedge core_clk);
        rst_n <= 1'b0;
        waitCyc(2);
        chkBit(shut, 1'b1);
        chkBit(lUp | lLow | bufEn, 1'b0);
        chkBit(rUp | rLow | sGood | irq, 1'b0);
        @(posedge core_clk);
        rst_n <= 1'b1;
        waitCyc(14);
        chkBit(sGood, 1'b0);
        chkBit(shut, 1'b1);
        waitCyc(1700);
        chkWord(32'(overlapCount), 32'h0);
        wrap_up();
    end
endmodule

// file: test/gate_driver_model.sv
// Behavioural gate drivers and current sense of the four bridge switches.
`timescale 1ns/10ps
module gate_driver_model (
    input wire logic core_clk,
    input wire logic leftUp,
    input wire logic leftLow,
    input wire logic rightUp,
    input wire logic rightLow,
    input wire logic overload,
    output logic noOvercurrent,
    output int overlapCount
);
    // The comparator output is high while the sensed current stays below the limit.
    assign noOvercurrent = !overload;
    // A leg with both switches on shorts the supply, so every such cycle is counted.
    always @(posedge core_clk) begin
        if ((leftUp && leftLow) || (rightUp && rightLow)) begin
            overlapCount <= overlapCount + 1;
        end
    end
endmodule
